// ===== verilog/bpgcb_pkg.sv
// constants for the bridge pcie/graphics configuration bit bank
package bpgcb_pkg;

  // =========================================================
  // bus and decode
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned DECODE_WIDTH = 12;
  localparam logic [11:0] WORD_ZERO_OFFSET = 12'h420;
  localparam logic [11:0] WORD_ONE_OFFSET = 12'h424;
  localparam logic [1:0] HTRANS_NONSEQ_BIT_MASK = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

  // =========================================================
  // reset values
  localparam logic [31:0] WORD_ZERO_RESET = 32'hCCCC3CE0;
  localparam logic [31:0] WORD_ONE_RESET = 32'h00000000;

  // =========================================================
  // general_config_word_zero fields
  localparam int unsigned W0_GROUP_A_PORT_GATE_LSB = 10;
  localparam int unsigned GROUP_A_PORTS = 4;
  localparam int unsigned W0_GROUP_A_ACCESS_ENABLE_BIT = 9;
  localparam int unsigned W0_GROUP_A_SOFT_RESET_BIT = 8;
  localparam int unsigned W0_DISPLAY_CLOCK_GATE_BIT = 7;
  localparam int unsigned W0_GRAPHICS_CORE_CLOCK_GATE_BIT = 6;
  localparam int unsigned W0_GRAPHICS_MEMORY_CLOCK_GATE_BIT = 5;
  localparam int unsigned W0_PCIE_REFCLK_SELECT_BIT = 2;
  localparam int unsigned W0_FIXED_ROUTING_SELECT_BIT = 0;

  // =========================================================
  // dma_route_and_link_status fields
  localparam int unsigned W1_BLOCK_GRAPHICS_MEMORY_CFG_BIT = 24;
  localparam int unsigned W1_CLOCK_READY_LSB = 8;
  localparam int unsigned CLOCK_READY_FLAGS = 12;
  localparam logic [31:0] W1_READ_ONLY_MASK = 32'h000FFF00;
  localparam int unsigned W1_UNCACHED_ACCEL_LSB = 1;
  localparam int unsigned UNCACHED_ACCEL_GROUPS = 5;
  localparam int unsigned W1_GRAPHICS_UNCACHED_ACCEL_BIT = 0;

  // =========================================================
  // forced-select index inside the strap force block
  localparam int unsigned FORCE_REFCLK_INDEX = 0;
  localparam int unsigned FORCE_ROUTING_INDEX = 1;
  localparam int unsigned FORCE_COUNT = 2;

endpackage

// ===== verilog/bpgcb_reg_if.sv
// register access channel between the bus slave and the bit bank
`timescale 1ns/1ps
interface bpgcb_reg_if;
  logic [11:0] rdAddr;
  logic [31:0] rdData;
  logic wrEn;
  logic [11:0] wrAddr;
  logic [31:0] wrData;

  modport slave (
    output rdAddr,
    output wrEn,
    output wrAddr,
    output wrData,
    input rdData
  );

  modport bank (
    input rdAddr,
    input wrEn,
    input wrAddr,
    input wrData,
    output rdData
  );
endinterface

// ===== verilog/bpgcb_ahb_slave.sv
// zero-wait ahb-lite slave front end
`timescale 1ns/1ps
module bpgcb_ahb_slave (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  bpgcb_reg_if.slave regs
);
  logic takeAccess;
  logic dataPhaseWrite_reg;
  logic [11:0] wrAddr_reg;
  logic [31:0] hrdata_reg;

  // only word transfers are issued; size is not checked
  assign takeAccess = hsel & |(htrans & bpgcb_pkg::HTRANS_NONSEQ_BIT_MASK) & hready;

  // =========================================================
  // address phase capture
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dataPhaseWrite_reg <= 1'h0;
      wrAddr_reg <= '0;
    end else begin
      dataPhaseWrite_reg <= takeAccess & hwrite;
      if (takeAccess) begin
        wrAddr_reg <= haddr[bpgcb_pkg::DECODE_WIDTH-1:0];
      end
    end
  end

  // =========================================================
  // read data register, loaded at the address phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata_reg <= '0;
    end else if (takeAccess & ~hwrite) begin
      hrdata_reg <= regs.rdData;
    end
  end

  assign regs.rdAddr = haddr[bpgcb_pkg::DECODE_WIDTH-1:0];
  assign regs.wrEn = dataPhaseWrite_reg;
  assign regs.wrAddr = wrAddr_reg;
  assign regs.wrData = hwdata;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'h1;
  assign hresp = bpgcb_pkg::HRESP_OKAY;
endmodule

// ===== verilog/bpgcb_strap_force.sv
// registered or of stored select bits with their force straps
`timescale 1ns/1ps
module bpgcb_strap_force #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] storedBits,
  input wire logic [WIDTH-1:0] forceStraps,
  output logic [WIDTH-1:0] effectiveBits
);
  logic [WIDTH-1:0] effective_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      effective_reg <= '0;
    end else begin
      effective_reg <= storedBits | forceStraps;
    end
  end

  assign effectiveBits = effective_reg;
endmodule

// ===== verilog/bpgcb_config_bits.sv
// pcie and graphics configuration/status bit bank behind ahb-lite
// Contract
// RULE1: bits 12..10 gate group a ports 2..0
// RULE2: bit 9 enables group a access
// RULE3: bit 8 holds group a in reset
// RULE4: bits 7..5 gate display, core, memory
// RULE5: bit 2 selects internal pcie reference clock
// RULE6: refclk strap forces effective select high
// RULE7: bit 0 selects fixed address routing
// RULE8: routing strap forces effective routing high
// RULE9: word one bit 24 blocks memory config
// RULE10: word one bits 19..8 read clock ready
// RULE11: word one bits 5..1 uncached acceleration
// RULE12: word one bit 0 graphics acceleration
// RULE13: word one resets to all zero
// RULE14: bit 13 gates group a port 3
// RULE15: read-only writes ignored, reserved bits stored
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bpgcb_config_bits (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic forceInternalPcieRefclk,
  input wire logic forceFixedRouting,
  input wire logic [11:0] portClockReady,
  output logic [3:0] groupAPortClockGate,
  output logic groupAAccessEnable,
  output logic groupASoftReset,
  output logic displayClockGate,
  output logic graphicsCoreClockGate,
  output logic graphicsMemoryClockGate,
  output logic pcieRefclkInternal,
  output logic fixedRoutingSelect,
  output logic blockGraphicsMemoryCfg,
  output logic [4:0] groupUncachedAccel,
  output logic graphicsUncachedAccel
);
  // =========================================================
  // functions
  function automatic logic hitsWord(input logic [11:0] addr, input logic [11:0] offset);
    hitsWord = (addr == offset);
  endfunction

  function automatic logic [31:0] placeReady(input logic [11:0] flags);
    placeReady = {20'h00000, flags} << bpgcb_pkg::W1_CLOCK_READY_LSB;
  endfunction

  // =========================================================
  // bus slave
  bpgcb_reg_if regs ();

  bpgcb_ahb_slave u_slave (
    .clk_sys(clk_sys),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regs(regs.slave)
  );

  // =========================================================
  // storage
  logic [31:0] wordZero_reg;
  logic [31:0] wordZero_next;
  logic [31:0] wordOne_reg;
  logic [31:0] wordOne_next;
  logic [11:0] clockReady_reg;

  always_comb begin
    wordZero_next = wordZero_reg;
    if (regs.wrEn && hitsWord(regs.wrAddr, bpgcb_pkg::WORD_ZERO_OFFSET)) begin
      wordZero_next = regs.wrData; // [RULE15]
    end
  end

  always_comb begin
    wordOne_next = wordOne_reg;
    if (regs.wrEn && hitsWord(regs.wrAddr, bpgcb_pkg::WORD_ONE_OFFSET)) begin
      // status bits never stored; reserved bits kept as written
      wordOne_next = regs.wrData & ~bpgcb_pkg::W1_READ_ONLY_MASK; // [RULE15]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wordZero_reg <= bpgcb_pkg::WORD_ZERO_RESET;
    end else begin
      wordZero_reg <= wordZero_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wordOne_reg <= bpgcb_pkg::WORD_ONE_RESET; // [RULE13]
    end else begin
      wordOne_reg <= wordOne_next;
    end
  end

  // =========================================================
  // clock-ready status sampling
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clockReady_reg <= '0;
    end else begin
      clockReady_reg <= portClockReady; // [RULE10]
    end
  end

  // =========================================================
  // read mux, forwarding a write in flight
  always_comb begin
    if (hitsWord(regs.rdAddr, bpgcb_pkg::WORD_ZERO_OFFSET)) begin
      regs.rdData = wordZero_next;
    end else if (hitsWord(regs.rdAddr, bpgcb_pkg::WORD_ONE_OFFSET)) begin
      regs.rdData = wordOne_next | placeReady(clockReady_reg); // [RULE10]
    end else begin
      regs.rdData = bpgcb_pkg::UNMAPPED_READ_VALUE;
    end
  end

  // =========================================================
  // forced selects
  logic [1:0] storedSelects;
  logic [1:0] forceStraps;
  logic [1:0] effectiveSelects;

  assign storedSelects[bpgcb_pkg::FORCE_REFCLK_INDEX] =
    wordZero_reg[bpgcb_pkg::W0_PCIE_REFCLK_SELECT_BIT]; // [RULE5]
  assign storedSelects[bpgcb_pkg::FORCE_ROUTING_INDEX] =
    wordZero_reg[bpgcb_pkg::W0_FIXED_ROUTING_SELECT_BIT]; // [RULE7]
  assign forceStraps[bpgcb_pkg::FORCE_REFCLK_INDEX] = forceInternalPcieRefclk; // [RULE6]
  assign forceStraps[bpgcb_pkg::FORCE_ROUTING_INDEX] = forceFixedRouting; // [RULE8]

  bpgcb_strap_force #(
    .WIDTH(bpgcb_pkg::FORCE_COUNT)
  ) u_force (
    .clk_sys(clk_sys),
    .reset(reset),
    .storedBits(storedSelects),
    .forceStraps(forceStraps),
    .effectiveBits(effectiveSelects)
  );

  assign pcieRefclkInternal = effectiveSelects[bpgcb_pkg::FORCE_REFCLK_INDEX]; // [RULE6]
  assign fixedRoutingSelect = effectiveSelects[bpgcb_pkg::FORCE_ROUTING_INDEX]; // [RULE8]

  // =========================================================
  // control outputs straight from stored flops
  assign groupAPortClockGate = wordZero_reg[bpgcb_pkg::W0_GROUP_A_PORT_GATE_LSB
    +: bpgcb_pkg::GROUP_A_PORTS]; // [RULE1] [RULE14]
  assign groupAAccessEnable = wordZero_reg[bpgcb_pkg::W0_GROUP_A_ACCESS_ENABLE_BIT]; // [RULE2]
  assign groupASoftReset = wordZero_reg[bpgcb_pkg::W0_GROUP_A_SOFT_RESET_BIT]; // [RULE3]
  assign displayClockGate = wordZero_reg[bpgcb_pkg::W0_DISPLAY_CLOCK_GATE_BIT]; // [RULE4]
  assign graphicsCoreClockGate =
    wordZero_reg[bpgcb_pkg::W0_GRAPHICS_CORE_CLOCK_GATE_BIT]; // [RULE4]
  assign graphicsMemoryClockGate =
    wordZero_reg[bpgcb_pkg::W0_GRAPHICS_MEMORY_CLOCK_GATE_BIT]; // [RULE4]
  assign blockGraphicsMemoryCfg =
    wordOne_reg[bpgcb_pkg::W1_BLOCK_GRAPHICS_MEMORY_CFG_BIT]; // [RULE9]
  assign groupUncachedAccel = wordOne_reg[bpgcb_pkg::W1_UNCACHED_ACCEL_LSB
    +: bpgcb_pkg::UNCACHED_ACCEL_GROUPS]; // [RULE11]
  assign graphicsUncachedAccel =
    wordOne_reg[bpgcb_pkg::W1_GRAPHICS_UNCACHED_ACCEL_BIT]; // [RULE12]
endmodule

// ===== verification/bpgcb_config_bits_chk.sv
// port assertions for the configuration bit bank
`timescale 1ns/1ps
module bpgcb_config_bits_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic forceInternalPcieRefclk,
  input wire logic forceFixedRouting,
  input wire logic [11:0] portClockReady,
  input wire logic [3:0] groupAPortClockGate,
  input wire logic groupAAccessEnable,
  input wire logic groupASoftReset,
  input wire logic displayClockGate,
  input wire logic graphicsCoreClockGate,
  input wire logic graphicsMemoryClockGate,
  input wire logic pcieRefclkInternal,
  input wire logic fixedRoutingSelect,
  input wire logic blockGraphicsMemoryCfg,
  input wire logic [4:0] groupUncachedAccel,
  input wire logic graphicsUncachedAccel
);
  logic wrZeroReg, wrOneReg, rdOneReg;
  logic [8:0] zeroOut;
  logic [6:0] oneOut;
  logic taken;
  assign taken = hsel && htrans[1] && hready;
  assign zeroOut = {groupAPortClockGate, groupAAccessEnable, groupASoftReset,
    displayClockGate, graphicsCoreClockGate, graphicsMemoryClockGate};
  assign oneOut = {blockGraphicsMemoryCfg, groupUncachedAccel, graphicsUncachedAccel};

  // =========================================================
  // data phase trackers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrZeroReg <= 1'b0;
      wrOneReg <= 1'b0;
      rdOneReg <= 1'b0;
    end else begin
      wrZeroReg <= taken && hwrite && haddr[11:0] == bpgcb_pkg::WORD_ZERO_OFFSET;
      wrOneReg <= taken && hwrite && haddr[11:0] == bpgcb_pkg::WORD_ONE_OFFSET;
      rdOneReg <= taken && !hwrite && haddr[11:0] == bpgcb_pkg::WORD_ONE_OFFSET;
    end
  end

  // =========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_reset_vals; $fell(reset) |-> zeroOut == 9'h1E7 && oneOut == 7'h00; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
  property p_zero_write; wrZeroReg |=> zeroOut == $past(hwdata[13:5]); endproperty
  a_zero_write: assert property (p_zero_write) else $error("word zero outputs wrong");
  property p_zero_hold; $changed(zeroOut) |-> $past(wrZeroReg); endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("word zero moved unasked");
  property p_one_write; wrOneReg |=> oneOut == {$past(hwdata[24]), $past(hwdata[5:0])}; endproperty
  a_one_write: assert property (p_one_write) else $error("word one outputs wrong");
  property p_one_hold; $changed(oneOut) |-> $past(wrOneReg); endproperty
  a_one_hold: assert property (p_one_hold) else $error("word one moved unasked");
  property p_refclk;
    wrZeroReg |-> ##2 pcieRefclkInternal == ($past(hwdata[2], 2) | $past(forceInternalPcieRefclk));
  endproperty
  a_refclk: assert property (p_refclk) else $error("refclk select wrong");
  property p_route;
    wrZeroReg |-> ##2 fixedRoutingSelect == ($past(hwdata[0], 2) | $past(forceFixedRouting));
  endproperty
  a_route: assert property (p_route) else $error("routing select wrong");
  property p_force; !$past(reset) |-> (pcieRefclkInternal || !$past(forceInternalPcieRefclk))
    && (fixedRoutingSelect || !$past(forceFixedRouting)); endproperty
  a_force: assert property (p_force) else $error("strap did not force");
  property p_ready; rdOneReg |-> hrdata[19:8] == $past(portClockReady, 2); endproperty
  a_ready: assert property (p_ready) else $error("clock ready flags wrong");
endmodule

bind bpgcb_config_bits bpgcb_config_bits_chk u_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .forceInternalPcieRefclk(forceInternalPcieRefclk),
  .forceFixedRouting(forceFixedRouting),
  .portClockReady(portClockReady),
  .groupAPortClockGate(groupAPortClockGate),
  .groupAAccessEnable(groupAAccessEnable),
  .groupASoftReset(groupASoftReset),
  .displayClockGate(displayClockGate),
  .graphicsCoreClockGate(graphicsCoreClockGate),
  .graphicsMemoryClockGate(graphicsMemoryClockGate),
  .pcieRefclkInternal(pcieRefclkInternal),
  .fixedRoutingSelect(fixedRoutingSelect),
  .blockGraphicsMemoryCfg(blockGraphicsMemoryCfg),
  .groupUncachedAccel(groupUncachedAccel),
  .graphicsUncachedAccel(graphicsUncachedAccel)
);

// ===== verification/bpgcb_config_bits_tb.sv
// self-checking bench for the configuration bit bank
`timescale 1ns/1ps
module bpgcb_config_bits_tb;
  typedef struct {
    logic [31:0] addr;
    logic [31:0] wd;
    logic [11:0] rdy;
    logic [31:0] rd;
  } bpgcb_row_type;
  bpgcb_row_type rows [8];
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, z, o;
  logic forceInternalPcieRefclk = 1'b0, forceFixedRouting = 1'b0;
  logic [11:0] portClockReady = 12'h000;
  logic hreadyout, hresp, groupAAccessEnable, groupASoftReset, displayClockGate;
  logic graphicsCoreClockGate, graphicsMemoryClockGate, pcieRefclkInternal;
  logic fixedRoutingSelect, blockGraphicsMemoryCfg, graphicsUncachedAccel;
  logic [3:0] groupAPortClockGate;
  logic [4:0] groupUncachedAccel;
  int fails = 0;
  int nTests = 0;

  bpgcb_config_bits u_dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .forceInternalPcieRefclk(forceInternalPcieRefclk),
    .forceFixedRouting(forceFixedRouting),
    .portClockReady(portClockReady),
    .groupAPortClockGate(groupAPortClockGate),
    .groupAAccessEnable(groupAAccessEnable),
    .groupASoftReset(groupASoftReset),
    .displayClockGate(displayClockGate),
    .graphicsCoreClockGate(graphicsCoreClockGate),
    .graphicsMemoryClockGate(graphicsMemoryClockGate),
    .pcieRefclkInternal(pcieRefclkInternal),
    .fixedRoutingSelect(fixedRoutingSelect),
    .blockGraphicsMemoryCfg(blockGraphicsMemoryCfg),
    .groupUncachedAccel(groupUncachedAccel),
    .graphicsUncachedAccel(graphicsUncachedAccel)
  );

  always #5 clk_sys = ~clk_sys;

  // =========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic outs();
    logic [31:0] s0;
    logic [31:0] s1;
    logic [31:0] sRef;
    logic [31:0] eRef;
    s0 = 32'({groupAPortClockGate, groupAAccessEnable, groupASoftReset, displayClockGate,
      graphicsCoreClockGate, graphicsMemoryClockGate});
    s1 = 32'({blockGraphicsMemoryCfg, groupUncachedAccel, graphicsUncachedAccel});
    sRef = 32'(pcieRefclkInternal);
    eRef = 32'(z[2] | forceInternalPcieRefclk);
    check("word0 outputs", s0, 32'(z[13:5]));
    check("refclk", sRef, eRef);
    check("routing", 32'(fixedRoutingSelect), 32'(z[0] | forceFixedRouting));
    check("word1 outputs", s1, 32'({o[24], o[5:0]}));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    results();
  end

  // =========================================================
  // main sequence
  initial begin
    rows = '{'{32'h00000420, 32'hFFFFFFFF, 12'h000, 32'hFFFFFFFF},
      '{32'h00000420, 32'h00000000, 12'h000, 32'h00000000},
      '{32'h00000420, 32'h00002AA5, 12'h000, 32'h00002AA5},
      '{32'h00000420, 32'h5555155A, 12'h000, 32'h5555155A},
      '{32'h00000424, 32'hFFFFFFFF, 12'h000, 32'hFFF000FF},
      '{32'h00000424, 32'h00000000, 12'hFFF, 32'h000FFF00},
      '{32'h00000424, 32'h0100002A, 12'hA5C, 32'h010A5C2A},
      '{32'h00000424, 32'hFEF0F0D5, 12'h3C3, 32'hFEF3C3D5}};
    z = bpgcb_pkg::WORD_ZERO_RESET;
    o = 32'h0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    outs();
    @(posedge clk_sys);
    xfer(1'b0, 32'h00000424, 32'h0);
    check("reset word1", r, 32'h00000000);
    $display("test reset done");
    foreach (rows[i]) begin
      portClockReady <= rows[i].rdy;
      xfer(1'b1, rows[i].addr, rows[i].wd);
      xfer(1'b0, rows[i].addr, 32'h0);
      check("readback", r, rows[i].rd);
      if (rows[i].addr == 32'h00000420) begin
        z = rows[i].wd;
      end else begin
        o = rows[i].wd;
      end
      outs();
    end
    $display("test table done");
    forceInternalPcieRefclk <= 1'b1;
    forceFixedRouting <= 1'b1;
    repeat (2) @(posedge clk_sys);
    outs();
    xfer(1'b0, 32'h00000420, 32'h0);
    check("stored under strap", r, z);
    forceInternalPcieRefclk <= 1'b0;
    forceFixedRouting <= 1'b0;
    repeat (2) @(posedge clk_sys);
    outs();
    $display("test straps done");
    xfer(1'b1, 32'h00000428, 32'hFFFFFFFF);
    xfer(1'b0, 32'h00000428, 32'h0);
    check("unmapped read", r, 32'h00000000);
    xfer(1'b0, 32'h00000420, 32'h0);
    check("word0 after unmapped", r, z);
    $display("test unmapped done");
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    z = bpgcb_pkg::WORD_ZERO_RESET;
    o = 32'h0;
    @(posedge clk_sys);
    #1;
    outs();
    $display("test second reset done");
    results();
  end
endmodule
